// ==== include/tec_regs.vh ====
// How it works
// - one 8-bit up counter, three modes
// - timer and capture count prescaled system clock
// - event mode counts selected pin edges
// - each accepted clock or edge adds one
// - count FFH advancing raises overflow interrupt
// - overflow reloads preload, keeps counting
// - reading count register returns live count
// - write while stopped also loads counter
// - write while running updates preload, not counter
// - preload register has no reset value
// - mode field sits in control bits 7:6
// - control bit 4 is run enable
// - modes 00 none, 01 event, 10 timer, 11 capture
// - event edge select 0 rising, 1 falling
// - capture edge select sets start/stop edges
// - prescaler codes 0..7 divide 1..128
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define TEC_ADDR_W       4
`define TEC_OFS_COUNT    4'h0
`define TEC_OFS_CONTROL  4'h1
`define TEC_OFS_STATUS   4'h2
`define TEC_OFS_MASK     4'h3

// ****************************************************************
// control fields
// ****************************************************************
`define TEC_CTL_MODE_HI  7
`define TEC_CTL_MODE_LO  6
`define TEC_CTL_RUN      4
`define TEC_CTL_EDGE     3
`define TEC_CTL_PSC_HI   2
`define TEC_CTL_PSC_LO   0
`define TEC_CTL_WMASK    8'hDF
`define TEC_CTL_RESET    8'h08

`define TEC_MODE_NONE    2'h0
`define TEC_MODE_EVENT   2'h1
`define TEC_MODE_TIMER   2'h2
`define TEC_MODE_CAPTURE 2'h3

// ****************************************************************
// status and mask fields
// ****************************************************************
`define TEC_ST_OVF       0
`define TEC_ST_CAP       1
`define TEC_ST_MEAS      2
`define TEC_ST_RESET     2'h0
`define TEC_MASK_RESET   2'h0

// ****************************************************************
// prescaler and synchroniser
// ****************************************************************
`define TEC_PSC_W        7
`define TEC_SYNC_SETTLE  2'h3

`endif

// ==== tb/tec_pin_src.sv ====
`timescale 1ns/1ps
module tec_pin_src (
  input  wire       clk,
  input  wire       resetn,
  input  wire       go,
  input  wire [7:0] pulses,
  input  wire [7:0] half,
  output reg        pin,
  output wire       busy
);
  // pin idles low; each pulse is a rise then a fall, each level held
  // half cycles so the synchroniser never misses a level
  reg [8:0] left;
  reg [7:0] cnt;

  assign busy = (left != 9'h000);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin  <= 1'b0;
      left <= 9'h000;
      cnt  <= 8'h00;
    end else if (go) begin
      left <= {pulses, 1'b0};
      cnt  <= half;
    end else if (left != 9'h000) begin
      if (cnt == 8'h01) begin
        pin  <= ~pin;
        left <= left - 9'h001;
        cnt  <= half;
      end else begin
        cnt  <= cnt - 8'h01;
      end
    end
  end
endmodule

// ==== tb/tec_timer_checker.sv ====
`timescale 1ns/1ps
`include "tec_regs.vh"
module tec_timer_checker #(
  parameter CW = 8
) (
  input wire                   clk,
  input wire                   resetn,
  input wire                   external_count_pin,
  input wire [`TEC_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata,
  input wire                   irq
);
  // ****************************************************************
  // shadow copies of the plain read/write registers
  // ****************************************************************
  reg  [7:0] ctl;
  reg  [1:0] mask;
  wire       wr_clr;

  assign wr_clr = reg_wr && (reg_addr == `TEC_OFS_STATUS ||
                             reg_addr == `TEC_OFS_MASK);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl  <= `TEC_CTL_RESET;
      mask <= `TEC_MASK_RESET;
    end else if (reg_wr && reg_addr == `TEC_OFS_CONTROL) begin
      ctl  <= reg_wdata & `TEC_CTL_WMASK;
    end else if (reg_wr && reg_addr == `TEC_OFS_MASK) begin
      mask <= reg_wdata[1:0];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  ctl_read_a: assert property (
    $past(reg_rd && reg_addr == `TEC_OFS_CONTROL)
    |-> reg_rdata == $past(ctl))
    else $error("control readback wrong");
  unmapped_read_a: assert property (
    $past(reg_rd && reg_addr > 4'h3) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  status_read_a: assert property (
    $past(reg_rd && reg_addr == `TEC_OFS_STATUS)
    |-> reg_rdata[7:3] == 5'h00)
    else $error("status unused bits set");
  mask_read_a: assert property (
    $past(reg_rd && reg_addr == `TEC_OFS_MASK)
    |-> reg_rdata == {6'h00, $past(mask)})
    else $error("mask readback wrong");
  irq_masked_a: assert property (
    (mask == 2'h0 && $past(mask) == 2'h0) |-> !irq)
    else $error("interrupt high while fully masked");
  irq_fall_a: assert property (
    $fell(irq) |-> ($past(wr_clr) || $past(wr_clr, 2)))
    else $error("interrupt dropped without clear or mask write");
  irq_rise_a: assert property (
    $rose(irq) |-> (mask != 2'h0 || $past(mask) != 2'h0))
    else $error("interrupt rose with mask clear");

  // ****************************************************************
  // covers
  // ****************************************************************
  ovf_irq_c: cover property ($rose(irq));
  ctl_wr_c: cover property (reg_wr && reg_addr == `TEC_OFS_CONTROL);
  cnt_rd_c: cover property (reg_rd && reg_addr == `TEC_OFS_COUNT);
  pin_rise_c: cover property ($rose(external_count_pin));
endmodule

bind tec_timer tec_timer_checker #(.CW(CW)) u_chk (
  .clk                (clk),
  .resetn             (resetn),
  .external_count_pin (external_count_pin),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .irq                (irq)
);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "tec_regs.vh"
module testbench;
  reg        clk;
  reg        resetn;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_wr;
  reg        reg_rd;
  wire [7:0] reg_rdata;
  wire       irq;
  wire       pin;
  wire       busy;
  reg        go;
  reg  [7:0] n_pulse;
  reg  [7:0] half;
  reg  [7:0] v;
  integer    bad_count;
  integer    n_tests;
  integer    p;

  always #5 clk = ~clk;

  tec_timer #(.CW(8)) DUT (
    .clk                (clk),
    .resetn             (resetn),
    .external_count_pin (pin),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .irq                (irq)
  );

  tec_pin_src u_src (
    .clk    (clk),
    .resetn (resetn),
    .go     (go),
    .pulses (n_pulse),
    .half   (half),
    .pin    (pin),
    .busy   (busy)
  );

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
    end
  endtask

  task rdc(input [3:0] a, input [7:0] exp);
    reg [7:0] d;
    begin
      rd(a, d);
      check(d, exp);
    end
  endtask

  task irqc(input exp);
    begin
      @(posedge clk);
      #1;
      check({7'h00, irq}, {7'h00, exp});
    end
  endtask

  // waits are bounded; trailing cycles let the synchroniser drain
  task pulses(input [7:0] n, input [7:0] h);
    integer k;
    begin
      @(posedge clk);
      go      <= 1'b1;
      n_pulse <= n;
      half    <= h;
      @(posedge clk);
      go      <= 1'b0;
      #1;
      for (k = 0; k < 4000 && busy; k = k + 1) begin
        @(posedge clk);
        #1;
      end
      repeat (6) @(posedge clk);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  initial begin
    #300000;
    bad_count = bad_count + 1;
    stop_test;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    n_pulse = 8'h00;
    half = 8'h02;
    bad_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdc(`TEC_OFS_CONTROL, 8'h08);
    rdc(`TEC_OFS_STATUS, 8'h00);
    rdc(`TEC_OFS_MASK, 8'h00);
    rdc(`TEC_OFS_COUNT, 8'h00);
    rdc(4'h7, 8'h00);
    wr(`TEC_OFS_CONTROL, 8'hFF);
    rdc(`TEC_OFS_CONTROL, 8'hDF);
    wr(`TEC_OFS_CONTROL, 8'h40);
    wr(`TEC_OFS_COUNT, 8'h10);
    rdc(`TEC_OFS_COUNT, 8'h10);
    pulses(8'h03, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'h10);
    wr(`TEC_OFS_CONTROL, 8'h10);
    pulses(8'h03, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'h10);
    wr(`TEC_OFS_CONTROL, 8'h50);
    pulses(8'h05, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'h15);
    wr(`TEC_OFS_CONTROL, 8'h58);
    pulses(8'h03, 8'h03);
    rdc(`TEC_OFS_COUNT, 8'h18);
    wr(`TEC_OFS_CONTROL, 8'h48);
    rdc(`TEC_OFS_COUNT, 8'h18);
    // overflow with preload changed while running
    wr(`TEC_OFS_CONTROL, 8'h40);
    wr(`TEC_OFS_COUNT, 8'hF0);
    wr(`TEC_OFS_CONTROL, 8'h50);
    wr(`TEC_OFS_COUNT, 8'h20);
    rdc(`TEC_OFS_COUNT, 8'hF0);
    wr(`TEC_OFS_MASK, 8'h01);
    pulses(8'h0F, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'hFF);
    rdc(`TEC_OFS_STATUS, 8'h00);
    pulses(8'h01, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'h20);
    rdc(`TEC_OFS_STATUS, 8'h01);
    irqc(1'b1);
    wr(`TEC_OFS_MASK, 8'h00);
    irqc(1'b0);
    wr(`TEC_OFS_MASK, 8'h01);
    irqc(1'b1);
    wr(`TEC_OFS_STATUS, 8'h01);
    irqc(1'b0);
    rdc(`TEC_OFS_STATUS, 8'h00);
    pulses(8'h02, 8'h02);
    rdc(`TEC_OFS_COUNT, 8'h22);
    // timer mode, every ratio; the run spans 16 ticks, the two edges
    // of the stop write included, and one tick of phase slack is taken
    for (p = 0; p < 8; p = p + 1) begin
      wr(`TEC_OFS_CONTROL, 8'h80 | p[7:0]);
      wr(`TEC_OFS_COUNT, 8'h00);
      wr(`TEC_OFS_CONTROL, 8'h90 | p[7:0]);
      repeat ((16 << p) - 2) @(posedge clk);
      wr(`TEC_OFS_CONTROL, 8'h80 | p[7:0]);
      rd(`TEC_OFS_COUNT, v);
      check({7'h00, v >= 8'd15 && v <= 8'd17}, 8'h01);
    end
    // capture: start on fall, stop on rise, low level lasts 10 clocks
    wr(`TEC_OFS_CONTROL, 8'hC0);
    wr(`TEC_OFS_COUNT, 8'h00);
    wr(`TEC_OFS_CONTROL, 8'hD0);
    pulses(8'h02, 8'h0A);
    rd(`TEC_OFS_COUNT, v);
    check({7'h00, v >= 8'd8 && v <= 8'd12}, 8'h01);
    rdc(`TEC_OFS_STATUS, 8'h02);
    stop_test;
  end
endmodule

// ==== verilog/tec_pin_sync.v ====
`timescale 1ns/1ps
module tec_pin_sync (
  clk,
  resetn,
  pin,
  rise,
  fall
);
`include "tec_regs.vh"
  input  wire clk;
  input  wire resetn;
  input  wire pin;
  output wire rise;
  output wire fall;

  reg       sync_a;
  reg       sync_b;
  reg       last;
  reg [1:0] settle;

  // settle hides the edge the reset value of last would fake
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
      settle <= 2'h0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last   <= sync_b;
      if (settle != `TEC_SYNC_SETTLE)
        settle <= settle + 2'h1;
    end
  end

  // edges come only from the second stage, so each counts once
  assign rise = (settle == `TEC_SYNC_SETTLE) & sync_b & ~last;
  assign fall = (settle == `TEC_SYNC_SETTLE) & ~sync_b & last;
endmodule

// ==== verilog/tec_prescaler.v ====
`timescale 1ns/1ps
module tec_prescaler #(
  parameter PW = 7
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       enable,
  input  wire [2:0] ratio_select,
  output wire       tick
);
  reg  [PW-1:0] div_cnt;
  wire [PW-1:0] ratio_mask;

  // restart from zero so the first tick after enable is a full period
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      div_cnt <= {PW{1'b0}};
    else if (!enable)
      div_cnt <= {PW{1'b0}};
    else
      div_cnt <= div_cnt + {{(PW-1){1'b0}}, 1'b1};
  end

  // code n gives a tick every 2**n cycles
  assign ratio_mask = ~({PW{1'b1}} << ratio_select);
  assign tick       = enable & ((div_cnt & ratio_mask) == ratio_mask);
endmodule

// ==== verilog/tec_timer.v ====
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module tec_timer #(
  parameter CW = 8
) (
  clk,
  resetn,
  external_count_pin,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  irq
);
`include "tec_regs.vh"
  input  wire                   clk;
  input  wire                   resetn;
  input  wire                   external_count_pin;
  input  wire [`TEC_ADDR_W-1:0] reg_addr;
  input  wire [7:0]             reg_wdata;
  input  wire                   reg_wr;
  input  wire                   reg_rd;
  output reg  [7:0]             reg_rdata;
  output reg                    irq;

  // ****************************************************************
  // capture state machine encoding
  // ****************************************************************
  localparam PW_IDLE = 3'b001;
  localparam PW_MEAS = 3'b010;
  localparam PW_DONE = 3'b100;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [7:0]    timer_control;
  reg  [CW-1:0] count;
  reg  [CW-1:0] preload;
  reg  [1:0]    status;
  reg  [1:0]    mask;
  reg  [2:0]    pw_state;

  // ****************************************************************
  // next values
  // ****************************************************************
  reg  [CW-1:0] next_count;
  reg  [1:0]    next_status;
  reg  [2:0]    next_pw_state;
  reg  [7:0]    next_rdata;
  reg           count_tick;
  reg  [7:0]    next_control;
  reg  [1:0]    next_mask;
  reg  [CW-1:0] next_preload;

  // ****************************************************************
  // decoded fields and strobes
  // ****************************************************************
  wire [1:0]    mode_select;
  wire          mode_select_high;
  wire          mode_select_low;
  wire          count_run_enable;
  wire          active_edge_select;
  wire [2:0]    prescaler_ratio_select;
  wire          prescaler_input_clock;
  wire          internal_mode;
  wire          capture_mode;
  wire          mode_timer;
  wire          run_capture;
  wire          pw_measuring;
  wire          event_edge;
  wire          load_stopped;
  wire          psc_tick;
  wire          pin_rise;
  wire          pin_fall;
  wire          start_edge;
  wire          stop_edge;
  wire          count_full;
  wire          overflow;
  wire          capture_done;
  wire          wr_count;
  wire          wr_control;
  wire          wr_status;
  wire          wr_mask;

  // ****************************************************************
  // control field decode
  // ****************************************************************
  assign mode_select_high       = timer_control[`TEC_CTL_MODE_HI];
  assign mode_select_low        = timer_control[`TEC_CTL_MODE_LO];
  assign mode_select            = {mode_select_high, mode_select_low};
  assign count_run_enable       = timer_control[`TEC_CTL_RUN];
  assign active_edge_select     = timer_control[`TEC_CTL_EDGE];
  assign prescaler_ratio_select =
    timer_control[`TEC_CTL_PSC_HI:`TEC_CTL_PSC_LO];

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // mode 00 leaves every decoded flag low, so nothing counts
  assign mode_timer    = (mode_select == `TEC_MODE_TIMER);
  assign capture_mode  = (mode_select == `TEC_MODE_CAPTURE);
  assign internal_mode = mode_timer | capture_mode;
  assign run_capture   = count_run_enable & capture_mode;

  // ****************************************************************
  // bus write decode
  // ****************************************************************
  assign wr_count   = reg_wr & (reg_addr == `TEC_OFS_COUNT);
  assign wr_control = reg_wr & (reg_addr == `TEC_OFS_CONTROL);
  assign wr_status  = reg_wr & (reg_addr == `TEC_OFS_STATUS);
  assign wr_mask    = reg_wr & (reg_addr == `TEC_OFS_MASK);

  // ****************************************************************
  // clock sources
  // ****************************************************************
  tec_pin_sync u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (external_count_pin),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // the divider only runs while the internal clock is in use,
  // so a stopped timer restarts with a full prescaler period
  assign prescaler_input_clock = count_run_enable & internal_mode;

  tec_prescaler #(
    .PW (`TEC_PSC_W)
  ) u_prescaler (
    .clk          (clk),
    .resetn       (resetn),
    .enable       (prescaler_input_clock),
    .ratio_select (prescaler_ratio_select),
    .tick         (psc_tick)
  );

  // ****************************************************************
  // capture edges
  // ****************************************************************
  // select 0 measures a low pulse, select 1 a high pulse
  assign start_edge = active_edge_select ? pin_rise : pin_fall;
  assign stop_edge  = active_edge_select ? pin_fall : pin_rise;

  // in event mode select 0 counts rising edges, 1 falling ones
  assign event_edge   = active_edge_select ? pin_fall : pin_rise;

  // the measuring state is the middle bit of the one-hot code
  assign pw_measuring = pw_state[1];

  // ****************************************************************
  // count enable per mode
  // ****************************************************************
  // event mode counts pin edges; timer and capture modes count prescaler ticks
  always @* begin
    count_tick = 1'b0;
    case (mode_select)
      `TEC_MODE_EVENT: begin
        count_tick = count_run_enable & event_edge;
      end
      `TEC_MODE_TIMER: begin
        count_tick = count_run_enable & psc_tick;
      end
      `TEC_MODE_CAPTURE: begin
        count_tick = count_run_enable & psc_tick &
                     pw_measuring;
      end
      default: begin
        count_tick = 1'b0;
      end
    endcase
  end

  assign count_full = (count == {CW{1'b1}});
  assign overflow   = count_tick & count_full;
  assign capture_done = run_capture & pw_measuring & stop_edge;
  // a write while running reaches the preload, not the count
  assign load_stopped = wr_count & ~count_run_enable;

  // ****************************************************************
  // counter
  // ****************************************************************
  always @* begin
    next_count = count;
    if (load_stopped)
      next_count = reg_wdata[CW-1:0];
    else if (overflow)
      next_count = preload;
    else if (count_tick)
      next_count = count + {{(CW-1){1'b0}}, 1'b1};
  end

  // with run low no tick or reload reaches the count; only a count write changes it
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      count <= {CW{1'b0}};
    else
      count <= next_count;
  end

  // every count write lands here, running or not; an overflow in the
  // same cycle still reloads the value from before the write
  always @* begin
    next_preload = preload;
    if (wr_count)
      next_preload = reg_wdata[CW-1:0];
  end

  // no reset: contents are unknown until software writes them
  always @(posedge clk) begin
    preload <= next_preload;
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // bit 5 has no storage behind it and always reads zero
  always @* begin
    next_control = timer_control;
    if (wr_control)
      next_control = reg_wdata & `TEC_CTL_WMASK;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      timer_control <= `TEC_CTL_RESET;
    else
      timer_control <= next_control;
  end

  // ****************************************************************
  // pulse width capture sequencer
  // ****************************************************************
  always @* begin
    next_pw_state = pw_state;
    if (!run_capture) begin
      next_pw_state = PW_IDLE;
    end else begin
      case (pw_state)
        PW_IDLE: begin
          if (start_edge)
            next_pw_state = PW_MEAS;
        end
        PW_MEAS: begin
          if (stop_edge)
            next_pw_state = PW_DONE;
        end
        PW_DONE: begin
          // held until a count write, or run or capture mode going off, re-arms it,
          // so the measured width is not overwritten
          if (wr_count)
            next_pw_state = PW_IDLE;
        end
        default: begin
          next_pw_state = PW_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      pw_state <= PW_IDLE;
    else
      pw_state <= next_pw_state;
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // a new event in the clearing cycle wins over the clear
  always @* begin
    next_status = status;
    if (wr_status)
      next_status = status & ~reg_wdata[1:0];
    next_status[`TEC_ST_OVF] = next_status[`TEC_ST_OVF] |
                               overflow;
    next_status[`TEC_ST_CAP] = next_status[`TEC_ST_CAP] |
                               capture_done;
  end

  always @* begin
    next_mask = mask;
    if (wr_mask)
      next_mask = reg_wdata[1:0];
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= `TEC_ST_RESET;
      mask   <= `TEC_MASK_RESET;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  // built from the next values so irq changes on the same edge as the
  // status and mask flops; a registered output costs no extra cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(next_status & next_mask);
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // zero outside the answer cycle lets other reads share one bus
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TEC_OFS_COUNT: begin
          next_rdata[CW-1:0] = count;
        end
        `TEC_OFS_CONTROL: begin
          next_rdata = timer_control;
        end
        `TEC_OFS_STATUS: begin
          next_rdata = {5'h00, pw_measuring, status};
        end
        `TEC_OFS_MASK: begin
          next_rdata = {6'h00, mask};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end
endmodule
